// ==== rtl/bcse_pkg.sv ====
// Constants for the sync-word and status-set evaluation block
package bcse_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_GO = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_TIMEBASE = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // ----------------------------------------------------------------
  // Configuration bits
  // ----------------------------------------------------------------
  localparam int CFG_BCAST_CHECK_ENABLE = 0;
  localparam int CFG_EVEN_TIMETAG_FORCE = 2;
  localparam int CFG_TIMETAG_SYNC_ENABLE = 3;
  localparam int CFG_TB32_SELECT = 4;
  localparam int CFG_W = 5;
  localparam logic [4:0] CFG_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Control word bits
  // ----------------------------------------------------------------
  localparam int CW_SYNC_TIMETAG_SELECT = 15;
  localparam int CW_MSG_ERROR_IGNORE = 14;
  localparam int CW_SRQ_IGNORE = 13;
  localparam int CW_BUSY_IGNORE = 12;
  localparam int CW_SUBSYS_IGNORE = 11;
  localparam int CW_TFLAG_IGNORE = 10;
  localparam int CW_RSV_IGNORE = 9;
  localparam int CW_BCAST_EXPECTED_FLAG = 5;

  // ----------------------------------------------------------------
  // Command and status word fields
  // ----------------------------------------------------------------
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 11;
  localparam int CMD_TR = 10;
  localparam int CMD_SA_HI = 9;
  localparam int CMD_SA_LO = 5;
  localparam int CMD_MC_HI = 4;
  localparam int CMD_MC_LO = 0;
  localparam logic [4:0] SA_MODE_A = 5'h00;
  localparam logic [4:0] SA_MODE_B = 5'h1f;
  localparam logic [4:0] SYNC_WITH_DATA_MODE_CODE = 5'h11;
  localparam int ST_MSG_ERROR = 10;
  localparam int ST_SRQ = 8;
  localparam int ST_RSV_HI = 7;
  localparam int ST_RSV_LO = 5;
  localparam int ST_BCAST_RCVD = 4;
  localparam int ST_BUSY = 3;
  localparam int ST_SUBSYS = 2;
  localparam int ST_TFLAG = 0;

  // ----------------------------------------------------------------
  // Interrupt bits and AXI responses
  // ----------------------------------------------------------------
  localparam int IRQ_SENT = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_STATUS_SET = 2;
  localparam int IRQ_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : bcse_pkg

// ==== rtl/bcse_status_eval.sv ====
// Status-set cause evaluation for one received status word
module bcse_status_eval
  import bcse_pkg::*;
(
  // Message context
  input wire logic [15:0] ctrl_word,
  input wire logic [15:0] cmd_word,
  input wire logic bcast_check_enable,
  // Received status word
  input wire logic [15:0] status_word,
  // Causes: 0 msg error, 1 other masks, 2 broadcast, 3 address
  output logic [3:0] causes,
  output logic status_set
);

  logic me_cause;
  logic srq_cause;
  logic busy_cause;
  logic subsys_cause;
  logic tflag_cause;
  logic rsv_cause;
  logic bc_exp;
  logic bc_rcvd;

  assign me_cause = ~ctrl_word[CW_MSG_ERROR_IGNORE]
                    & status_word[ST_MSG_ERROR];

  assign srq_cause = ~ctrl_word[CW_SRQ_IGNORE] & status_word[ST_SRQ];
  assign busy_cause = ~ctrl_word[CW_BUSY_IGNORE] & status_word[ST_BUSY];
  assign subsys_cause = ~ctrl_word[CW_SUBSYS_IGNORE]
                        & status_word[ST_SUBSYS];
  assign tflag_cause = ~ctrl_word[CW_TFLAG_IGNORE] & status_word[ST_TFLAG];
  assign rsv_cause = ~ctrl_word[CW_RSV_IGNORE]
                     & (|status_word[ST_RSV_HI:ST_RSV_LO]);

  assign bc_exp = ctrl_word[CW_BCAST_EXPECTED_FLAG];
  assign bc_rcvd = status_word[ST_BCAST_RCVD];

  assign causes[0] = me_cause;
  assign causes[1] = srq_cause | busy_cause | subsys_cause | tflag_cause
                     | rsv_cause;
  assign causes[2] = bcast_check_enable ? (~bc_exp & bc_rcvd)
                                        : (bc_exp ^ bc_rcvd);
  assign causes[3] = status_word[ADDR_HI:ADDR_LO] != cmd_word[ADDR_HI:ADDR_LO];
  assign status_set = |causes;

endmodule // bcse_status_eval

// ==== rtl/bcse_top.sv ====
// Message sync-word source and status-set evaluator behind AXI4-Lite
module bcse_top
  import bcse_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Word to the bus encoder
  output logic tx_valid,
  output logic [15:0] tx_word,
  // Status word from the bus decoder
  input wire logic rx_status_valid,
  input wire logic [15:0] rx_status_word,
  // Message result
  output logic result_valid,
  output logic status_set,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] awaddr_r, araddr_q;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [CFG_W-1:0] cfg_r;
  logic [15:0] ctrl_r, cmd_r, data_r, last_status_r;
  logic [31:0] tb_r, tb_nxt;
  logic busy_r, tx_valid_r, result_valid_r, status_set_r, irq_r;
  logic [15:0] tx_word_r, sync_word;
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_ev, irq_stat_nxt;
  logic aw_hs, w_hs, ar_hs, wr_do, wr_hit, rd_hit;
  logic [31:0] rd_word;
  logic start, is_mode_cmd, is_sync, use_tt, rx_take;
  logic [3:0] causes;
  logic eval_set;

  // ----------------------------------------------------------------
  // Bus handshakes and decode
  // ----------------------------------------------------------------
  assign aw_hs = s_axi_awvalid & awready_r;
  assign w_hs = s_axi_wvalid & wready_r;
  assign ar_hs = s_axi_arvalid & arready_r;
  // Both halves held and no response pending
  assign wr_do = ~awready_r & ~wready_r & ~bvalid_r;
  assign wr_hit = awaddr_r == OFS_CFG || awaddr_r == OFS_CTRL
                  || awaddr_r == OFS_CMD || awaddr_r == OFS_DATA
                  || awaddr_r == OFS_GO || awaddr_r == OFS_IRQ_STAT
                  || awaddr_r == OFS_IRQ_MASK;
  assign rd_hit = wr_hit_rd(s_axi_araddr);

  function automatic logic wr_hit_rd(input logic [7:0] a);
    wr_hit_rd = a == OFS_CFG || a == OFS_CTRL || a == OFS_CMD
                || a == OFS_DATA || a == OFS_GO || a == OFS_RESULT
                || a == OFS_TIMEBASE || a == OFS_IRQ_STAT
                || a == OFS_IRQ_MASK;
  endfunction

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? nw[15:8] : old[15:8],
               strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  // Read data selection
  assign araddr_q = s_axi_araddr;
  assign rd_word =
    araddr_q == OFS_CFG ? {27'h0, cfg_r} :
    araddr_q == OFS_CTRL ? {16'h0, ctrl_r} :
    araddr_q == OFS_CMD ? {16'h0, cmd_r} :
    araddr_q == OFS_DATA ? {16'h0, data_r} :
    araddr_q == OFS_GO ? {31'h0, busy_r} :
    araddr_q == OFS_RESULT ? {15'h0, status_set_r, last_status_r} :
    araddr_q == OFS_TIMEBASE ? tb_r :
    araddr_q == OFS_IRQ_STAT ? {29'h0, irq_stat_r} :
    araddr_q == OFS_IRQ_MASK ? {29'h0, irq_mask_r} : 32'h0;

  // ----------------------------------------------------------------
  // Message start and sync word source
  // ----------------------------------------------------------------
  assign start = wr_do & (awaddr_r == OFS_GO) & wstrb_r[0] & wdata_r[0]
                 & ~busy_r;
  assign is_mode_cmd = cmd_r[CMD_SA_HI:CMD_SA_LO] == SA_MODE_A
                       || cmd_r[CMD_SA_HI:CMD_SA_LO] == SA_MODE_B;
  assign is_sync = is_mode_cmd & ~cmd_r[CMD_TR]
                   & (cmd_r[CMD_MC_HI:CMD_MC_LO] == SYNC_WITH_DATA_MODE_CODE);
  // option gated by enable and code
  assign use_tt = is_sync & ctrl_r[CW_SYNC_TIMETAG_SELECT]
                  & cfg_r[CFG_TIMETAG_SYNC_ENABLE];
  assign sync_word = use_tt
    ? {tb_r[15:1], tb_r[0] & ~cfg_r[CFG_EVEN_TIMETAG_FORCE]} : data_r;
  assign rx_take = rx_status_valid & busy_r;

  // Time base: 16-bit wrap unless 32-bit selected
  assign tb_nxt = cfg_r[CFG_TB32_SELECT] ? tb_r + 32'h1
                  : {16'h0, tb_r[15:0] + 16'h1};

  // Interrupt events and write-one-to-clear
  assign irq_ev = {rx_take & eval_set, rx_take, start};
  assign irq_stat_nxt =
    (irq_stat_r & ~((wr_do && awaddr_r == OFS_IRQ_STAT && wstrb_r[0])
                    ? wdata_r[IRQ_W-1:0] : {IRQ_W{1'b0}})) | irq_ev;

  // ----------------------------------------------------------------
  // Status evaluation
  // ----------------------------------------------------------------
  // cause evaluation
  bcse_status_eval u_eval (
    .ctrl_word(ctrl_r),
    .cmd_word(cmd_r),
    .bcast_check_enable(cfg_r[CFG_BCAST_CHECK_ENABLE]),
    .status_word(rx_status_word),
    .causes(causes),
    .status_set(eval_set)
  );

  // ----------------------------------------------------------------
  // AXI channel state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= CFG_RESET;
      ctrl_r <= 16'h0000;
      cmd_r <= 16'h0000;
      data_r <= 16'h0000;
      irq_mask_r <= {IRQ_W{1'b0}};
      irq_stat_r <= {IRQ_W{1'b0}};
      tb_r <= 32'h0;
    end else begin
      tb_r <= tb_nxt;
      irq_stat_r <= irq_stat_nxt;
      if (wr_do && awaddr_r == OFS_CFG && wstrb_r[0])
        cfg_r <= wdata_r[CFG_W-1:0];
      if (wr_do && awaddr_r == OFS_CTRL)
        ctrl_r <= merge16(ctrl_r, wdata_r, wstrb_r);
      if (wr_do && awaddr_r == OFS_CMD)
        cmd_r <= merge16(cmd_r, wdata_r, wstrb_r);
      if (wr_do && awaddr_r == OFS_IRQ_MASK && wstrb_r[0])
        irq_mask_r <= wdata_r[IRQ_W-1:0];
      // sent sync word saved in data block
      if (start && is_sync)
        data_r <= sync_word;
      else if (wr_do && awaddr_r == OFS_DATA)
        data_r <= merge16(data_r, wdata_r, wstrb_r);
    end
  end

  // ----------------------------------------------------------------
  // Message sequencing and result
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_word_r <= 16'h0000;
      result_valid_r <= 1'b0;
      status_set_r <= 1'b0;
      last_status_r <= 16'h0000;
      irq_r <= 1'b0;
    end else begin
      tx_valid_r <= start;
      result_valid_r <= rx_take;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
      if (start) begin
        busy_r <= 1'b1;
        tx_word_r <= sync_word;
      end else if (rx_take) begin
        busy_r <= 1'b0;
      end
      // latched OR of causes on status arrival
      if (rx_take) begin
        status_set_r <= eval_set;
        last_status_r <= rx_status_word;
      end
    end
  end

  // Output drive
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign tx_valid = tx_valid_r;
  assign tx_word = tx_word_r;
  assign result_valid = result_valid_r;
  assign status_set = status_set_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // non-sync messages untouched
  a_sync_only_code: assert property (
    @(posedge aclk) disable iff (!aresetn)
    start && !is_sync |=> tx_valid_r && tx_word_r == $past(data_r))
    else $error("option changed a non-sync message word");

  a_sync_from_ram: assert property (
    @(posedge aclk) disable iff (!aresetn)
    start && is_sync && !(ctrl_r[CW_SYNC_TIMETAG_SELECT]
      && cfg_r[CFG_TIMETAG_SYNC_ENABLE])
    |=> tx_word_r == $past(data_r))
    else $error("sync word not taken from data block");

  a_sync_from_tb: assert property (
    @(posedge aclk) disable iff (!aresetn)
    start && use_tt |=> tx_word_r[15:1] == $past(tb_r[15:1]))
    else $error("sync word not taken from time base");

  a_even_force: assert property (
    @(posedge aclk) disable iff (!aresetn)
    start && use_tt |=> tx_word_r[0] ==
      ($past(tb_r[0]) && !$past(cfg_r[CFG_EVEN_TIMETAG_FORCE])))
    else $error("time-tag bit zero wrong");

  a_sync_writeback: assert property (
    @(posedge aclk) disable iff (!aresetn)
    start && is_sync |=> data_r == tx_word_r ##1 tx_valid_r == 1'b0)
    else $error("sent sync word not saved");

  a_me_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rx_take && !ctrl_r[CW_MSG_ERROR_IGNORE] && rx_status_word[ST_MSG_ERROR]
    |=> result_valid_r && status_set_r)
    else $error("message error not flagged");

  a_me_ignore: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rx_take && ctrl_r[CW_MSG_ERROR_IGNORE] && rx_status_word[ST_MSG_ERROR]
    && causes[3:1] == 3'h0 |=> !status_set_r)
    else $error("masked message error counted");

  a_mask_pairs: assert property (
    @(posedge aclk) disable iff (!aresetn)
    causes[1] == ((!ctrl_r[CW_SRQ_IGNORE] && rx_status_word[ST_SRQ])
      || (!ctrl_r[CW_BUSY_IGNORE] && rx_status_word[ST_BUSY])
      || (!ctrl_r[CW_SUBSYS_IGNORE] && rx_status_word[ST_SUBSYS])
      || (!ctrl_r[CW_TFLAG_IGNORE] && rx_status_word[ST_TFLAG])
      || (!ctrl_r[CW_RSV_IGNORE]
          && rx_status_word[ST_RSV_HI:ST_RSV_LO] != 3'h0)))
    else $error("mask pairing wrong");

  a_bcast_check: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rx_take && (cfg_r[CFG_BCAST_CHECK_ENABLE]
      ? (!ctrl_r[CW_BCAST_EXPECTED_FLAG] && rx_status_word[ST_BCAST_RCVD])
      : (ctrl_r[CW_BCAST_EXPECTED_FLAG] != rx_status_word[ST_BCAST_RCVD]))
    |=> status_set_r && irq_stat_r[IRQ_STATUS_SET])
    else $error("broadcast mismatch not flagged");

  a_addr_match: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rx_take && rx_status_word[ADDR_HI:ADDR_LO] != cmd_r[ADDR_HI:ADDR_LO]
    |=> status_set_r)
    else $error("address mismatch not flagged");

  a_result_or: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rx_take |=> result_valid_r && status_set_r == |$past(causes)
      ##1 !result_valid_r)
    else $error("status-set result wrong");

endmodule // bcse_top

// ==== test/bcse_rt_model.sv ====
// Remote terminal model answering each sent word with a status word
module bcse_rt_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Word from the block and answer set up by the bench
  input wire logic tx_valid,
  input wire logic [15:0] rsp_word,
  input wire logic [7:0] rsp_delay,
  // Status word towards the block
  output logic rx_status_valid,
  output logic [15:0] rx_status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r = 8'h00;
  logic [15:0] last_r = 16'h0000;
  initial rx_status_valid = 1'b0;
  initial rx_status_word = 16'hffff;
  // Answer after a delay; outside the answer the lines show a changed value
  always @(posedge aclk) begin
    rx_status_valid <= 1'b0;
    rx_status_word <= ~last_r;
    if (!aresetn) begin
      cnt_r <= 8'h00;
    end else if (tx_valid) begin
      cnt_r <= rsp_delay;
    end else if (cnt_r == 8'h01) begin
      rx_status_valid <= 1'b1;
      rx_status_word <= rsp_word;
      last_r <= rsp_word;
      cnt_r <= 8'h00;
    end else if (cnt_r > 8'h01) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule // bcse_rt_model

// ==== test/bcse_top_tb.sv ====
// Self-checking bench for the sync-word and status-set block
module bcse_top_tb;
  import bcse_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rsp_delay;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, t0, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, tx_valid, rx_status_valid;
  logic [15:0] tx_word, rx_status_word, rsp_word, tx_got;
  logic result_valid, status_set, irq, ss;
  int fails = 0;
  int comparisons = 0;
  bcse_top bcse_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_valid, .tx_word,
    .rx_status_valid, .rx_status_word, .result_valid, .status_set, .irq);
  bcse_rt_model bcse_rt_model_inst (.aclk, .aresetn, .tx_valid,
    .rsp_word, .rsp_delay, .rx_status_valid, .rx_status_word);
  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Capture of each sent word
  always @(posedge aclk) begin
    if (tx_valid === 1'b1) tx_got <= tx_word;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // AXI write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
    // Let an edge pass so the next call never re-drives bready at once
    @(posedge aclk);
  endtask
  // AXI read: data and response taken at the handshake edge
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    // Let an edge pass so the next call never re-drives rready at once
    @(posedge aclk);
  endtask
  // One message: set up, start, let the terminal answer, wait for result
  task automatic msg(input logic [31:0] cfg, input logic [31:0] ctl,
                     input logic [15:0] cmd, input logic [15:0] st);
    // control block set before the start
    wr(OFS_CFG, cfg);
    wr(OFS_CTRL, ctl);
    wr(OFS_CMD, {16'h0, cmd});
    wr(OFS_DATA, 32'h1235);
    rsp_word <= st;
    rsp_delay <= rsp_delay ^ 8'h06;
    wr(OFS_GO, 32'h1);
    do @(posedge aclk); while (result_valid !== 1'b1);
    ss = status_set;
  endtask
  task automatic sts(input logic [31:0] cfg, input logic [31:0] ctl,
                     input logic [15:0] st, input logic e);
    msg(cfg, ctl, 16'h2812, st);
    check({31'h0, ss}, {31'h0, e});
  endtask
  // Time tag word lies just after the time base read before the start
  task automatic tchk;
    check({31'h0, 16'(tx_got - t0[15:0]) < 16'h40}, 1);
    rd(OFS_DATA);
    check(rv, {16'h0, tx_got});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_CFG);
    check(rv, 32'h0);
    wr(8'h24, 32'h5, RESP_SLVERR);
    wr(OFS_RESULT, 32'h1, RESP_SLVERR);
    rd(8'h24);
    check({rv[29:0], rr}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_sync;
    msg(0, 32'h8000, 16'h2811, 16'h2800);
    check({16'h0, tx_got}, 32'h1235);
    msg(8, 0, 16'h2811, 16'h2800);
    check({16'h0, tx_got}, 32'h1235);
    msg(8, 32'h8000, 16'h2812, 16'h2800);
    check({16'h0, tx_got}, 32'h1235);
    rd(OFS_TIMEBASE);
    t0 = rv;
    msg(8, 32'h8000, 16'h2811, 16'h2800);
    tchk();
    for (int i = 0; i < 2; i++) begin
      rd(OFS_TIMEBASE);
      t0 = rv;
      msg(12, 32'h8000, 16'h2811, 16'h2800);
      check({31'h0, tx_got[0]}, 0);
      tchk();
    end
    rd(OFS_TIMEBASE);
    t0 = rv;
    msg(24, 32'h8000, 16'h2bf1, 16'h2800);
    tchk();
  endtask
  task automatic t_status;
    int mb[8] = '{14, 13, 12, 11, 10, 9, 9, 9};
    int sb[8] = '{10, 8, 3, 2, 0, 5, 6, 7};
    sts(1, 0, 16'h2800, 0);
    for (int i = 0; i < 8; i++) begin
      sts(1, 0, 16'h2800 | (16'h1 << sb[i]), 1);
      sts(1, 1 << mb[i], 16'h2800 | (16'h1 << sb[i]), 0);
    end
    sts(1, 32'h2000, 16'h2908, 1);
    sts(1, 0, 16'h2810, 1);
    sts(1, 32'h20, 16'h2800, 0);
    sts(1, 32'h20, 16'h2810, 0);
    sts(0, 32'h20, 16'h2800, 1);
    sts(0, 0, 16'h2810, 1);
    sts(0, 32'h20, 16'h2810, 0);
    sts(1, 0, 16'h3000, 1);
  endtask
  task automatic t_irq;
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h4);
    sts(1, 0, 16'h2c00, 1);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 1);
    rd(OFS_RESULT);
    check(rv, 32'h12c00);
    rd(OFS_IRQ_STAT);
    check(rv, 32'h7);
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 0);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h4);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 0);
    rd(OFS_IRQ_STAT);
    check(rv, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    rsp_word = 16'h0;
    rsp_delay = 8'h01;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_sync();
    t_status();
    t_irq();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    tally_and_finish();
  end
endmodule // bcse_top_tb
